// ### hw/pso_pkg.sv
// Package: shared constants and carrier types for the sink status outputs
package pso_pkg;

  // Contract flag configuration codes
  localparam logic [1:0] PSO_CFG_SINGLE = 2'h0;
  localparam logic [1:0] PSO_CFG_BAD = 2'h1;
  localparam logic [1:0] PSO_CFG_PROFILE = 2'h2;
  localparam logic [1:0] PSO_CFG_CURRENT = 2'h3;
  localparam logic [1:0] PSO_CFG_RESET = PSO_CFG_PROFILE;

  // Advertised Type-C current codes
  localparam logic [1:0] PSO_CUR_NONE = 2'h0;
  localparam logic [1:0] PSO_CUR_DEFAULT = 2'h1;
  localparam logic [1:0] PSO_CUR_1A5 = 2'h2;
  localparam logic [1:0] PSO_CUR_3A0 = 2'h3;

  // Profile numbers for explicit contracts
  localparam logic [1:0] PSO_PROFILE_HI = 2'h2;
  localparam logic [1:0] PSO_PROFILE_LO = 2'h3;

  // Discharge timer width and time base
  localparam int PSO_DISCHARGE_CTL_W = 8;
  localparam int PSO_TICK_NS = 1000;
  localparam int PSO_CLK_NS = 8;
  localparam int PSO_TICK_CYC = PSO_TICK_NS / PSO_CLK_NS;
  localparam int PSO_TICK_W = 7;

  // Attach state from the Type-C state machine
  typedef struct packed {
    logic source;      // source attached
    logic debug;       // debug accessory attached
    logic [1:0] cur;   // advertised current code
  } pso_attach_t;

  // Protocol events, one-cycle pulses
  typedef struct packed {
    logic ps_ready;    // supply-ready received
    logic request;     // request sent for new profile
    logic hard_reset;  // hard reset seen
    logic err_rec;     // entering error recovery
    logic lower_v;     // move to lower voltage
  } pso_event_t;

  // Open-drain status outputs, 1 = pull low
  typedef struct packed {
    logic connection_flag;
    logic sink_path_enable_n;
    logic contract_flag_hi_v;
    logic contract_flag_lo_v;
    logic discharge_ctl;
    logic bus_sense_discharge;
  } pso_pins_t;

endpackage

// ### hw/pso_discharge_ctl_timer.sv
// Discharge timer: runs for a configured number of ticks
`timescale 1ns/1ps
module pso_discharge_ctl_timer
  import pso_pkg::*;
#(
  parameter int TICK_CYC = PSO_TICK_CYC
)
(
  input wire logic i_clock,                      // System clock
  input wire logic i_reset_n,                    // Async reset, active low
  input wire logic i_start,                      // Start or restart pulse
  input wire logic [PSO_DISCHARGE_CTL_W-1:0] i_length,   // Length in ticks
  output logic o_active                          // Discharge running
);
  typedef struct packed {
    logic [PSO_TICK_W-1:0] pre;
    logic [PSO_DISCHARGE_CTL_W-1:0] left;
    logic active;
  } pso_tmr_t;

  pso_tmr_t st_r;
  pso_tmr_t st_nxt;

  // Prescaler gives one tick enable per microsecond
  always_comb
  begin
    st_nxt = st_r;
    if (i_start)
    begin
      st_nxt.pre = '0;
      st_nxt.left = i_length;
      st_nxt.active = (i_length != '0);
    end
    else if (st_r.active)
    begin
      if (st_r.pre == PSO_TICK_W'(TICK_CYC - 1))
      begin
        st_nxt.pre = '0;
        st_nxt.left = st_r.left - PSO_DISCHARGE_CTL_W'(1);
        if (st_r.left == PSO_DISCHARGE_CTL_W'(1))
          st_nxt.active = 1'b0;
      end
      else
        st_nxt.pre = st_r.pre + PSO_TICK_W'(1);
    end
  end

  // State register
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign o_active = st_r.active;
endmodule

// ### hw/pso_status_out.sv
// Sink status outputs: attach flag, power path, contract flags, discharge
//
// Notes on behaviour
// RL1 - During reset both configuration channel pins are left released.
// RL2 - The external discharge output turns on together with the internal one.
// RL3 - Discharge starts on detach, lower voltage, hard reset, error recovery.
// RL4 - Discharge length comes from a non-volatile setting input.
// RL5 - The connection flag pulls low when a source connection is valid.
// RL6 - The connection flag also pulls low for a debug accessory.
// RL7 - A two-bit setting picks the contract flag mode; code 01 is unusable.
// RL8 - In mode 00 the power path follows source attach; flags stay released.
// RL9 - In mode 10 the high flag pulls low only under a second-profile contract.
// RL10 - In mode 10 the low flag pulls low only under a third-profile contract.
// RL11 - In mode 11 the high flag pulls low when the source offers 3.0 A.
// RL12 - In mode 11 the low flag pulls low when the source offers 1.5 A.
// RL13 - In mode 10 a flag sets only after the supply-ready message.
// RL14 - A source-led renegotiation releases the flag when the request is sent.
// RL15 - On detach flags hold while the path releases; new attach clears them.
// RL16 - Every status output is open drain: pulled low or released only.
`timescale 1ns/1ps
module pso_status_out
  import pso_pkg::*;
(
  input wire logic i_clock,                        // 125 MHz clock
  input wire logic i_reset_n,                      // Async reset, active low
  input wire logic i_reset,                        // Reset pin, active high
  input wire pso_pkg::pso_attach_t i_attach,       // Attach state
  input wire pso_pkg::pso_event_t i_event,         // Protocol events
  input wire logic [1:0] i_profile,                // Negotiated profile
  input wire logic [1:0] i_contract_flag_config,   // Flag mode setting
  input wire logic [PSO_DISCHARGE_CTL_W-1:0] i_discharge_ctl_len,  // Discharge ticks
  output logic o_cc1_oe_n,                         // CC1 drive enable
  output logic o_cc2_oe_n,                         // CC2 drive enable
  output pso_pkg::pso_pins_t o_pins_oe_n,          // Status pins, low = pull
  output logic o_cfg_invalid                       // Mode setting unusable
);
  import pso_pkg::*;

  typedef struct packed {
    logic [1:0] rst_s;        // reset pin synchroniser
    pso_attach_t att_s1;      // attach synchroniser, first stage
    pso_attach_t att_s2;      // attach synchroniser, second stage
    logic attached_d;         // attach seen last cycle
    logic [1:0] cfg;          // captured mode setting
    logic cfg_done;           // setting captured
    logic flag_hi;            // contract flag, high profile
    logic flag_lo;            // contract flag, low profile
    logic cc_hold;            // CC pins released
    logic cfg_bad;            // setting is 01
    pso_pins_t pins;          // status outputs, 1 = pull low
  } pso_state_t;

  pso_state_t st_r;
  pso_state_t st_nxt;
  logic discharge_ctl_start;
  logic discharge_ctl_active;
  logic attached;

  // Attach level for detach detection; only the second stage is read
  assign attached = st_r.att_s2.source | st_r.att_s2.debug;

  // Discharge triggers; detach seen on synchronised attach
  assign discharge_ctl_start = (st_r.attached_d & ~attached)            // RL3
                     | i_event.lower_v | i_event.hard_reset
                     | i_event.err_rec;

  // Timer length is taken from the setting, never fixed here
  pso_discharge_ctl_timer #(
    .TICK_CYC(PSO_TICK_CYC)
  ) u_discharge_ctl (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_start(discharge_ctl_start),                                      // RL3
    .i_length(i_discharge_ctl_len),                                     // RL4
    .o_active(discharge_ctl_active)
  );

  // Next state for all outputs
  always_comb
  begin
    st_nxt = st_r;
    // Pins and attach state come from outside, two stages first
    st_nxt.rst_s = {st_r.rst_s[0], i_reset};
    st_nxt.att_s1 = i_attach;
    st_nxt.att_s2 = st_r.att_s1;
    st_nxt.attached_d = attached;
    st_nxt.cc_hold = st_r.rst_s[1];                             // RL1
    // Setting latched once after reset release, as from memory
    if (!st_r.cfg_done)
    begin
      st_nxt.cfg = i_contract_flag_config;
      st_nxt.cfg_done = 1'b1;
    end
    st_nxt.cfg_bad = (st_r.cfg == PSO_CFG_BAD);                 // RL7
    // Profile flags: new attach clears, else request clears, else ready sets
    if (attached & ~st_r.attached_d)
    begin
      st_nxt.flag_hi = 1'b0;                                    // RL15
      st_nxt.flag_lo = 1'b0;
    end
    else if (i_event.request)
    begin
      st_nxt.flag_hi = 1'b0;                                    // RL14
      st_nxt.flag_lo = 1'b0;
    end
    else if (i_event.ps_ready && st_r.att_s2.source)
    begin
      st_nxt.flag_hi = (i_profile == PSO_PROFILE_HI);           // RL13
      st_nxt.flag_lo = (i_profile == PSO_PROFILE_LO);
    end
    if (i_event.hard_reset)
    begin
      st_nxt.flag_hi = 1'b0;
      st_nxt.flag_lo = 1'b0;
    end
    // Connection flag for source or debug accessory
    st_nxt.pins.connection_flag = st_r.att_s2.source            // RL5
                                | st_r.att_s2.debug;            // RL6
    // Power path released on detach in every mode
    st_nxt.pins.sink_path_enable_n = st_r.att_s2.source;        // RL8 RL15
    case (st_r.cfg)                                             // RL7
      PSO_CFG_SINGLE:
      begin
        st_nxt.pins.contract_flag_hi_v = 1'b0;                  // RL8
        st_nxt.pins.contract_flag_lo_v = 1'b0;
      end
      PSO_CFG_PROFILE:
      begin
        st_nxt.pins.contract_flag_hi_v = st_r.flag_hi;          // RL9
        st_nxt.pins.contract_flag_lo_v = st_r.flag_lo;          // RL10
      end
      PSO_CFG_CURRENT:
      begin
        st_nxt.pins.contract_flag_hi_v = st_r.att_s2.source
          & (st_r.att_s2.cur == PSO_CUR_3A0);                   // RL11
        st_nxt.pins.contract_flag_lo_v = st_r.att_s2.source
          & (st_r.att_s2.cur == PSO_CUR_1A5);                   // RL12
      end
      default:
      begin
        // Unusable code: keep flags released
        st_nxt.pins.contract_flag_hi_v = 1'b0;
        st_nxt.pins.contract_flag_lo_v = 1'b0;
      end
    endcase
    // Both discharge outputs from one timer, so they move together
    st_nxt.pins.discharge_ctl = discharge_ctl_active;                   // RL2
    st_nxt.pins.bus_sense_discharge = discharge_ctl_active;             // RL2
    // Reset pin releases everything
    if (st_r.rst_s[1])
    begin
      st_nxt.pins = '0;
      st_nxt.flag_hi = 1'b0;
      st_nxt.flag_lo = 1'b0;
    end
  end

  // State register; CC pins start released
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      st_r <= '0;
      st_r.cfg <= PSO_CFG_RESET;
      st_r.cc_hold <= 1'b1;                                     // RL1
    end
    else
      st_r <= st_nxt;
  end

  // Open drain: enable low pulls the pin low, never driven high
  always_comb
  begin
    o_pins_oe_n = ~st_r.pins;                                   // RL16
    o_cc1_oe_n = 1'b1;
    o_cc2_oe_n = 1'b1;
    o_cfg_invalid = st_r.cfg_bad;
  end
endmodule

// ### dv/pso_pullup_model.sv
// Partner model: external pull-ups on the open-drain status lines
`timescale 1ns/1ps
module pso_pullup_model
  import pso_pkg::*;
(
  input wire pso_pkg::pso_pins_t i_pins_oe_n, // Pull enables, low = pull
  output logic [5:0] o_level                  // Wire levels seen by system
);
  // Released line floats up to the pull-up, never left at old value
  assign o_level = i_pins_oe_n;
endmodule

// ### dv/pso_status_out_props.sv
// Checker: timing relations of the sink status outputs
`timescale 1ns/1ps
module pso_status_out_props
  import pso_pkg::*;
(
  input wire logic i_clock,                        // Clock
  input wire logic i_reset_n,                      // Async reset
  input wire logic i_reset,                        // Reset pin
  input wire pso_pkg::pso_attach_t i_attach,       // Attach state
  input wire pso_pkg::pso_event_t i_event,         // Events
  input wire logic [1:0] i_profile,                // Profile
  input wire logic [1:0] i_contract_flag_config,   // Flag mode
  input wire logic [PSO_DISCHARGE_CTL_W-1:0] i_discharge_ctl_len,  // Discharge ticks
  input wire logic o_cc1_oe_n,                     // CC1 enable
  input wire logic o_cc2_oe_n,                     // CC2 enable
  input wire pso_pkg::pso_pins_t o_pins_oe_n,      // Status pins
  input wire logic o_cfg_invalid                   // Bad mode
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  logic discharge_ctl_ev;
  // Protocol events that must start a bus discharge; detach is not included
  assign discharge_ctl_ev = i_event.hard_reset | i_event.err_rec | i_event.lower_v;
  // Five samples cover the two-stage synchroniser plus output register
  sequence src_held;
    i_attach.source [*5];
  endsequence
  sequence src_gone;
    !i_attach.source [*5];
  endsequence
  chk_cc_hiz: assert property (o_cc1_oe_n && o_cc2_oe_n)
    else $error("cc pin driven");
  chk_discharge_ctl_pair: assert property (o_pins_oe_n.discharge_ctl ==
    o_pins_oe_n.bus_sense_discharge) else $error("discharge pins differ");
  chk_discharge_ctl_start: assert property (discharge_ctl_ev && i_discharge_ctl_len != 8'h00
    |-> ##[2:3] !o_pins_oe_n.discharge_ctl) else $error("no discharge");
  chk_conn_flag: assert property ((i_attach.source || i_attach.debug)
    [*5] |-> !o_pins_oe_n.connection_flag) else $error("no connect");
  chk_path_on: assert property (src_held |->
    !o_pins_oe_n.sink_path_enable_n) else $error("path not enabled");
  chk_path_off: assert property (src_gone |->
    o_pins_oe_n.sink_path_enable_n) else $error("path left enabled");
  chk_bad_mode: assert property (o_cfg_invalid |->
    o_pins_oe_n.contract_flag_hi_v && o_pins_oe_n.contract_flag_lo_v)
    else $error("flag pulled in bad mode");
  chk_single_mode: assert property (i_contract_flag_config ==
    PSO_CFG_SINGLE |-> o_pins_oe_n.contract_flag_hi_v &&
    o_pins_oe_n.contract_flag_lo_v) else $error("flag in single mode");
  chk_rate_hi: assert property ((i_attach.source &&
    i_attach.cur == PSO_CUR_3A0) [*5] ##0 i_contract_flag_config ==
    PSO_CFG_CURRENT |-> !o_pins_oe_n.contract_flag_hi_v)
    else $error("high flag not pulled");
  chk_request_drop: assert property (i_event.request &&
    !o_pins_oe_n.contract_flag_hi_v |-> ##[2:3]
    o_pins_oe_n.contract_flag_hi_v) else $error("flag kept on request");
endmodule
bind pso_status_out pso_status_out_props u_props (.i_clock(i_clock),
  .i_reset_n(i_reset_n), .i_reset(i_reset), .i_attach(i_attach),
  .i_event(i_event), .i_profile(i_profile), .i_discharge_ctl_len(i_discharge_ctl_len),
  .i_contract_flag_config(i_contract_flag_config), .o_cc1_oe_n(o_cc1_oe_n),
  .o_cc2_oe_n(o_cc2_oe_n), .o_pins_oe_n(o_pins_oe_n),
  .o_cfg_invalid(o_cfg_invalid));

// ### dv/pso_status_out_test.sv
// Testbench: self-checking run of the sink status outputs
`timescale 1ns/1ps
module pso_status_out_test;
  import pso_pkg::*;
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_reset = 1'b0;
  pso_attach_t att = '0;
  pso_event_t ev = '0;
  logic [1:0] prof = 2'h0;
  logic [1:0] cfg = PSO_CFG_RESET;
  logic [7:0] dlen = 8'h02;
  logic cc1, cc2, bad;
  pso_pins_t pins;
  logic [5:0] lvl;
  int n_mismatch = 0;
  int tests_run = 0;
  int n;
  always #4 i_clock = ~i_clock;
  pso_status_out u_dut (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_reset(i_reset), .i_attach(att), .i_event(ev), .i_profile(prof),
    .i_contract_flag_config(cfg), .i_discharge_ctl_len(dlen), .o_cc1_oe_n(cc1),
    .o_cc2_oe_n(cc2), .o_pins_oe_n(pins), .o_cfg_invalid(bad));
  pso_pullup_model u_pull (.i_pins_oe_n(pins), .o_level(lvl));
  // Inputs move 1 ns after the edge so sampling order never matters
  task automatic tick(int c);
    repeat (c) @(posedge i_clock);
    #1;
  endtask
  task automatic check(string nm, logic [8:0] seen, logic [8:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Mode is only captured after reset, so each mode needs a reset
  task automatic restart(logic [1:0] c);
    i_reset_n = 1'b0;
    cfg = c;
    att = '0;
    tick(12);
    i_reset_n = 1'b1;
    tick(2);
  endtask
  task automatic pulse(logic [4:0] e);
    ev = e;
    tick(1);
    ev = '0;
  endtask
  // Flag pair levels, hi then lo, 1 = released
  function automatic logic [1:0] exp_cur(logic [1:0] c, logic [1:0] cur);
    if (c != PSO_CFG_CURRENT)
      return 2'h3;
    return {cur != PSO_CUR_3A0, cur != PSO_CUR_1A5};
  endfunction
  initial
  begin
    n = $urandom(32'h41BC);
    for (int m = 0; m < 4; m++)
    begin
      restart(m[1:0]);
      att = '{1'b1, 1'b0, 2'($urandom_range(3))};
      tick(6);
      check("cfg_invalid", bad, m == 1);
      check("attach", lvl[5:4], 2'h0);
      check("flags", lvl[3:2], exp_cur(m[1:0], att.cur));
    end
    for (int r = 0; r < 8; r++)
    begin
      att.cur = 2'($urandom_range(3));
      tick(6);
      check("cur_flags", lvl[3:2], exp_cur(cfg, att.cur));
    end
    // Profile mode: set, renegotiate, detach, reattach
    restart(PSO_CFG_PROFILE);
    att = '{1'b1, 1'b0, PSO_CUR_DEFAULT};
    tick(6);
    prof = PSO_PROFILE_HI;
    pulse(5'h10);
    tick(3);
    check("hi_on", lvl[3:2], 2'h1);
    prof = PSO_PROFILE_LO;
    pulse(5'h18);
    tick(3);
    check("req_drop", lvl[3:2], 2'h3);
    pulse(5'h10);
    tick(3);
    check("lo_on", lvl[3:2], 2'h2);
    att.source = 1'b0;
    tick(6);
    check("detach", lvl[4:2], 3'h6);
    att.source = 1'b1;
    tick(6);
    check("reattach", lvl[4:2], 3'h3);
    tick(300);
    // Lower voltage, error recovery, hard reset each start a discharge
    for (int e = 0; e < 3; e++)
    begin
      pulse(5'(1 << e));
      tick(2);
      check("discharge_ctl_on", lvl[1:0], 2'h0);
      tick(300);
    end
    // Random length of one to three ticks, taken at the start pulse
    dlen = 8'(1 + $urandom_range(2));
    pulse(5'h01);
    n = 0;
    for (int w = 0; w < 400; w++)
    begin
      if (lvl[1:0] == 2'h0)
        n++;
      tick(1);
    end
    check("discharge_ctl_len", 9'(n), 9'(dlen * PSO_TICK_CYC));
    // A zero length setting starts no discharge at all
    dlen = 8'h00;
    pulse(5'h01);
    tick(3);
    check("discharge_ctl_zero", lvl[1:0], 2'h3);
    att = '{1'b0, 1'b1, PSO_CUR_NONE};
    tick(6);
    check("debug", lvl[5:4], 2'h1);
    att = '0;
    i_reset = 1'b1;
    tick(6);
    check("reset_pin", {cc1, cc2, lvl[5:2]}, 6'h3F);
    i_reset = 1'b0;
    tick(4);
    print_verdict();
  end
  // Watchdog against a hung run
  initial
  begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
endmodule
